// ### rtl/acp_compute.sv
// post-conversion compute unit with AHB-Lite register slave
//
// Overview of operation
// - extra hold capacitance follows its select, disconnected while converting.
// - three-bit mode field: 0 basic, 1 accumulate, 2 average, 3 burst, 4 lowpass.
// - basic mode keeps accumulator and counter; done flag and test every sample.
// - accumulate mode adds sample, counter increments and holds at ff.
// - accumulate mode sets done each conversion and tests every sample.
// - average mode: counter at/above repeat restarts at 1 with sample loaded.
// - average and lowpass test only when counter reaches repeat setting.
// - burst: start clears accumulator and counter, reconverts until count reached.
// - lowpass: accumulator becomes sample plus accumulator minus shifted accumulator.
// - lowpass: after repeat count every trigger updates and tests again.
// - double sampling feeds current result minus previous result.
// - shift divisions truncate toward lower value, never round.
// - accumulator is 16-bit signed, readable as one 16-bit word at the acc offset.
// - counter increments with each accumulated sample; target is repeat register.
// - clear bit clears accumulator, counter and overflow flag.
// - clear takes five cycles when running from the rc oscillator.
// - three-bit shift forms filter output from the accumulator.
// - lowpass cut-off set by shift, 1 to 5 from 0.72 to 0.032 rad.
// - burst keeps retriggering even with continuous sampling off.
//
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
module acp_compute
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // conversion core
    input wire acp_pkg::acp_conv_t conv,
    input wire logic conv_phase,
    output logic conv_go,
    output logic [acp_pkg::CAP_W-1:0] hold_cap_en,
    // threshold comparator
    output acp_pkg::acp_thr_t thr
);
    // control state
    logic [2:0] compute_mode_field;
    logic [2:0] shift_setting;
    logic double_sample_enable;
    logic cont_enable;
    logic rc_clock_sel;
    logic [acp_pkg::CAP_W-1:0] extra_hold_cap_select;
    logic [7:0] repeat_setting;
    // datapath state
    logic signed [15:0] accumulator;
    logic signed [15:0] filter_output;
    logic [7:0] sample_counter;
    logic accumulator_overflow_flag;
    logic conversion_done_flag;
    logic threshold_interrupt_flag;
    logic [acp_pkg::RES_W-1:0] latest_result;
    logic [acp_pkg::RES_W-1:0] previous_result;
    logic pair_second;
    logic [2:0] clr_cnt;
    // bus data phase
    logic wr_pend;
    logic [7:0] wr_addr;

    // address phase decode
    wire logic addr_valid = hsel && hready && htrans[1];
    wire logic rd_take = addr_valid && !hwrite;
    wire logic wr_take = addr_valid && hwrite;
    wire logic [7:0] a_ofs = haddr[7:0];
    wire logic wr_ctrl = wr_pend && (wr_addr == acp_pkg::OFS_CTRL);
    wire logic wr_rpt = wr_pend && (wr_addr == acp_pkg::OFS_RPT);
    wire logic wr_stat = wr_pend && (wr_addr == acp_pkg::OFS_STAT);
    wire logic go_write = wr_ctrl && hwdata[acp_pkg::CTRL_GO_BIT];
    wire logic clr_write = wr_ctrl && hwdata[acp_pkg::CTRL_CLR_BIT];
    // a ctrl write rewrites every field: act on the written mode and clock select
    wire logic clr_rc_new = hwdata[acp_pkg::CTRL_RCCLK_BIT];
    wire logic burst_start =
        go_write && (hwdata[acp_pkg::CTRL_MODE_LSB +: 3] == acp_pkg::MODE_BURST);
    wire logic clr_fire = (clr_cnt == 3'h1);
    wire logic clr_busy = (clr_cnt != 3'h0);

    // mode decode
    wire logic m_basic = (compute_mode_field == acp_pkg::MODE_BASIC);
    wire logic m_avg = (compute_mode_field == acp_pkg::MODE_AVG);
    wire logic m_burst = (compute_mode_field == acp_pkg::MODE_BURST);
    wire logic m_lpf = (compute_mode_field == acp_pkg::MODE_LPF);
    wire logic m_restart = m_avg || m_burst;

    // sample formation: first of a pair is only stored
    wire logic signed [15:0] res_ext = 16'($signed({1'b0, conv.result}));
    wire logic signed [15:0] prev_ext = 16'($signed({1'b0, latest_result}));
    wire logic signed [15:0] samp =
        double_sample_enable ? res_ext - prev_ext : res_ext;
    wire logic sample_go = conv.done && (!double_sample_enable || pair_second);

    // counter and accumulator decisions
    wire logic cnt_reached = (sample_counter >= repeat_setting);
    wire logic restart = m_restart && cnt_reached;
    wire logic [7:0] cnt_inc =
        (sample_counter == acp_pkg::CNT_MAX) ? sample_counter : sample_counter + 8'h01;
    wire logic [7:0] cnt_after = restart ? 8'h01 : cnt_inc;
    wire logic test_due = m_basic || (compute_mode_field == acp_pkg::MODE_ACCUM) ||
        (cnt_after >= repeat_setting);
    wire logic retrig = cont_enable || (m_burst && (cnt_after < repeat_setting));

    // kernel
    logic signed [15:0] acc_next;
    logic ovf;
    logic signed [15:0] shifted;
    acp_kernel u_kernel
    (
        .acc(accumulator),
        .samp(samp),
        .shift(shift_setting),
        .lpf_sel(m_lpf),
        .load_sel(restart),
        .acc_next(acc_next),
        .ovf(ovf),
        .shifted(shifted)
    );

    // readback mux
    wire logic [31:0] ctrl_rd = {3'h0, extra_hold_cap_select, 6'h00, clr_busy, conv_go,
        5'h00, rc_clock_sel, cont_enable, double_sample_enable, 1'b0, shift_setting,
        1'b0, compute_mode_field};
    wire logic [31:0] stat_rd = {16'h0000, sample_counter, 5'h00,
        accumulator_overflow_flag, threshold_interrupt_flag, conversion_done_flag};
    wire logic [31:0] res_rd = {6'h00, previous_result, 6'h00, latest_result};
    wire logic [31:0] next_hrdata =
        (a_ofs == acp_pkg::OFS_CTRL) ? ctrl_rd :
        (a_ofs == acp_pkg::OFS_RPT) ? {24'h000000, repeat_setting} :
        (a_ofs == acp_pkg::OFS_STAT) ? stat_rd :
        (a_ofs == acp_pkg::OFS_ACC) ? {16'h0000, accumulator} :
        (a_ofs == acp_pkg::OFS_FLTR) ? {16'h0000, filter_output} :
        (a_ofs == acp_pkg::OFS_RES) ? res_rd : 32'h00000000;

    // bus slave: zero wait states, always okay
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (rd_take)
            begin
                hrdata <= next_hrdata;
            end
            wr_pend <= wr_take;
            wr_addr <= a_ofs;
        end
    end

    // software settings
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            compute_mode_field <= acp_pkg::MODE_BASIC;
            shift_setting <= 3'h0;
            double_sample_enable <= 1'b0;
            cont_enable <= 1'b0;
            rc_clock_sel <= 1'b0;
            extra_hold_cap_select <= 5'h00;
            repeat_setting <= acp_pkg::RPT_RST;
        end
        else
        begin
            if (wr_ctrl)
            begin
                compute_mode_field <= hwdata[acp_pkg::CTRL_MODE_LSB +: 3];
                shift_setting <= hwdata[acp_pkg::CTRL_SHIFT_LSB +: 3];
                double_sample_enable <= hwdata[acp_pkg::CTRL_DSEN_BIT];
                cont_enable <= hwdata[acp_pkg::CTRL_CONT_BIT];
                rc_clock_sel <= hwdata[acp_pkg::CTRL_RCCLK_BIT];
                extra_hold_cap_select <= hwdata[acp_pkg::CTRL_CAP_LSB +: acp_pkg::CAP_W];
            end
            if (wr_rpt)
            begin
                repeat_setting <= hwdata[7:0];
            end
        end
    end

    // clear sequencing: the rc clock needs several cycles to finish a clear
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            clr_cnt <= 3'h0;
        end
        else if (clr_write && !clr_busy)
        begin
            clr_cnt <= clr_rc_new ? acp_pkg::CLR_CYC_RC : acp_pkg::CLR_CYC_SYS;
        end
        else if (clr_busy)
        begin
            clr_cnt <= clr_cnt - 3'h1;
        end
    end

    // accumulator, counter, overflow; the clear wins over a sample in its cycle
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            accumulator <= 16'h0000;
            sample_counter <= 8'h00;
            accumulator_overflow_flag <= 1'b0;
            filter_output <= 16'h0000;
        end
        else if (clr_fire)
        begin
            accumulator <= 16'h0000;
            sample_counter <= 8'h00;
            accumulator_overflow_flag <= 1'b0;
        end
        else if (burst_start)
        begin
            accumulator <= 16'h0000;
            sample_counter <= 8'h00;
        end
        else if (sample_go && !m_basic)
        begin
            accumulator <= acc_next;
            sample_counter <= cnt_after;
            accumulator_overflow_flag <= accumulator_overflow_flag || ovf;
        end
        else
        begin
            filter_output <= shifted;
        end
    end

    // result capture and pairing for double sampling
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            latest_result <= 10'h000;
            previous_result <= 10'h000;
            pair_second <= 1'b0;
        end
        else if (conv.done)
        begin
            latest_result <= conv.result;
            previous_result <= latest_result;
            pair_second <= double_sample_enable && !pair_second;
        end
        else if (!double_sample_enable)
        begin
            pair_second <= 1'b0;
        end
    end

    // flags: hardware set wins over a software clear in the same cycle
    wire logic clr_done = wr_stat && hwdata[acp_pkg::STAT_DONE_BIT];
    wire logic clr_thr = wr_stat && hwdata[acp_pkg::STAT_THR_BIT];
    wire logic thr_set = sample_go && test_due;
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            conversion_done_flag <= 1'b0;
            threshold_interrupt_flag <= 1'b0;
        end
        else
        begin
            conversion_done_flag <= conv.done || (conversion_done_flag && !clr_done);
            threshold_interrupt_flag <= thr_set || (threshold_interrupt_flag && !clr_thr);
        end
    end

    // outward strobes and conversion start
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            thr <= '0;
            conv_go <= 1'b0;
            hold_cap_en <= 5'h00;
        end
        else
        begin
            thr.test <= thr_set;
            thr.aov <= accumulator_overflow_flag || (sample_go && !m_basic && ovf);
            hold_cap_en <= conv_phase ? 5'h00 : extra_hold_cap_select;
            if (go_write)
            begin
                conv_go <= 1'b1;
            end
            else if (sample_go)
            begin
                conv_go <= retrig;
            end
            else if (conv.done && !cont_enable && !m_burst)
            begin
                conv_go <= 1'b0;
            end
        end
    end

    // checks
    property p_cap_off;
        @(posedge mclk) disable iff (sys_rst)
        conv_phase |=> (hold_cap_en == 5'h00);
    endproperty
    a_cap_off: assert property (p_cap_off) else $error("hold cap on during conversion");

    property p_basic_hold;
        @(posedge mclk) disable iff (sys_rst)
        (sample_go && m_basic && !clr_fire && !go_write) |=>
        $stable(accumulator) && $stable(sample_counter);
    endproperty
    a_basic_hold: assert property (p_basic_hold) else $error("basic mode changed state");

    property p_cnt_sat;
        @(posedge mclk) disable iff (sys_rst)
        (sample_go && !m_basic && !m_restart && !clr_fire && !go_write &&
        sample_counter == 8'hff) |=> (sample_counter == 8'hff);
    endproperty
    a_cnt_sat: assert property (p_cnt_sat) else $error("counter wrapped");

    property p_done_set;
        @(posedge mclk) disable iff (sys_rst)
        conv.done |=> conversion_done_flag;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done flag missed");

    property p_avg_restart;
        @(posedge mclk) disable iff (sys_rst)
        (sample_go && m_avg && cnt_reached && !clr_fire && !go_write) |=>
        (sample_counter == 8'h01) && (accumulator == $past(samp));
    endproperty
    a_avg_restart: assert property (p_avg_restart) else $error("average restart wrong");

    property p_test_gate;
        @(posedge mclk) disable iff (sys_rst)
        (sample_go && (m_avg || m_lpf) && !clr_fire && !go_write &&
        cnt_after < repeat_setting) |=> !thr.test;
    endproperty
    a_test_gate: assert property (p_test_gate) else $error("early threshold test");

    property p_burst_clear;
        @(posedge mclk) disable iff (sys_rst)
        (burst_start && !clr_fire) |=>
        (accumulator == 16'h0000) && (sample_counter == 8'h00) && conv_go;
    endproperty
    a_burst_clear: assert property (p_burst_clear) else $error("burst start not cleared");

    sequence s_clr_req_rc;
        clr_write && !clr_busy && clr_rc_new;
    endsequence
    sequence s_clr_done;
        ##6 (accumulator == 16'h0000) && (sample_counter == 8'h00) &&
        !accumulator_overflow_flag;
    endsequence
    property p_clr_rc;
        @(posedge mclk) disable iff (sys_rst)
        s_clr_req_rc |-> s_clr_done;
    endproperty
    a_clr_rc: assert property (p_clr_rc) else $error("rc clear latency wrong");

    property p_aov_sticky;
        @(posedge mclk) disable iff (sys_rst)
        (accumulator_overflow_flag && !clr_fire) |=> accumulator_overflow_flag;
    endproperty
    a_aov_sticky: assert property (p_aov_sticky) else $error("overflow flag lost");
endmodule

// ### rtl/acp_pkg.sv
// package: constants and types of the post-conversion compute unit
package acp_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_RPT = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_ACC = 8'h0c;
    localparam logic [7:0] OFS_FLTR = 8'h10;
    localparam logic [7:0] OFS_RES = 8'h14;
    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SHIFT_LSB = 4;
    localparam int CTRL_DSEN_BIT = 8;
    localparam int CTRL_CONT_BIT = 9;
    localparam int CTRL_RCCLK_BIT = 10;
    localparam int CTRL_GO_BIT = 16;
    localparam int CTRL_CLR_BIT = 17;
    localparam int CTRL_CAP_LSB = 24;
    // status register fields
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_THR_BIT = 1;
    localparam int STAT_AOV_BIT = 2;
    localparam int STAT_CNT_LSB = 8;
    // result register fields
    localparam int RES_PREV_LSB = 16;
    // widths
    localparam int RES_W = 10;
    localparam int CAP_W = 5;
    // computation mode codes
    localparam logic [2:0] MODE_BASIC = 3'h0;
    localparam logic [2:0] MODE_ACCUM = 3'h1;
    localparam logic [2:0] MODE_AVG = 3'h2;
    localparam logic [2:0] MODE_BURST = 3'h3;
    localparam logic [2:0] MODE_LPF = 3'h4;
    // reset value and counter limit
    localparam logic [7:0] RPT_RST = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hff;
    // accumulator clear latency, in clock cycles of the compute clock
    localparam logic [2:0] CLR_CYC_RC = 3'h5;
    localparam logic [2:0] CLR_CYC_SYS = 3'h1;
    // sample from the conversion core
    typedef struct packed {
        logic done;
        logic [RES_W-1:0] result;
    } acp_conv_t;
    // threshold test request toward the comparator
    typedef struct packed {
        logic test;
        logic aov;
    } acp_thr_t;
endpackage

// ### rtl/acp_kernel.sv
// arithmetic kernel: accumulator update, overflow and shifted output
`timescale 1ns/10ps
module acp_kernel
(
    // operands
    input wire logic signed [15:0] acc,
    input wire logic signed [15:0] samp,
    input wire logic [2:0] shift,
    input wire logic lpf_sel,
    input wire logic load_sel,
    // results
    output logic signed [15:0] acc_next,
    output logic ovf,
    output logic signed [15:0] shifted
);
    // arithmetic shift floors: truncation toward the lower value, no rounding
    wire logic signed [15:0] acc_shr = acc >>> shift;
    wire logic signed [16:0] add_in = lpf_sel ? 17'(acc) - 17'(acc_shr) : 17'(acc);
    wire logic signed [16:0] sum = add_in + 17'(samp);
    wire logic [15:0] acc_trunc = sum[15:0];

    // load replaces the accumulator: no overflow possible
    assign acc_next = load_sel ? samp : acc_trunc;
    assign ovf = !load_sel && (sum[16] != sum[15]);
    assign shifted = acc_shr;
endmodule

// ### dv/acp_core_model.sv
// conversion core stand-in: answers go requests with timed conversions
`timescale 1ns/10ps
module acp_core_model
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // request and random source
    input wire logic conv_go,
    input wire logic [15:0] rnd,
    // conversion outputs
    output acp_pkg::acp_conv_t conv,
    output logic conv_phase
);
    logic done;
    logic [4:0] left;
    logic [9:0] res;
    // result is only valid with done; stale data shows inverted
    assign conv = '{done: done, result: done ? res : ~res};
    always @(posedge mclk)
    begin
        done <= 1'b0;
        if (sys_rst)
        begin
            conv_phase <= 1'b0;
            res <= 10'h000;
        end
        else if (conv_phase)
        begin
            left <= left - 5'h01;
            if (left == 5'h00)
            begin
                conv_phase <= 1'b0;
                done <= 1'b1;
                res <= rnd[9:0];
            end
        end
        // no restart in the cycle of done: go is still seen high there
        else if (conv_go && !done)
        begin
            conv_phase <= 1'b1;
            left <= rnd[15] ? 5'h14 : {3'h0, rnd[11:10]} + 5'h02;
        end
    end
endmodule

// ### dv/adc_post_conversion_compute_test.sv
// self-checking bench of the post-conversion compute unit
`timescale 1ns/10ps
module adc_post_conversion_compute_test;
    logic mclk, sys_rst, hsel, hwrite, hreadyout, hresp, conv_go, conv_phase;
    logic [31:0] haddr, hwdata, hrdata, rd, seed, rv;
    logic [1:0] htrans;
    logic [2:0] hsize, mode, sh;
    logic [4:0] hold_cap_en, cap;
    logic [15:0] rnd, flt;
    logic [16:0] sum;
    logic [7:0] rpt, e_cnt;
    logic [9:0] last;
    logic ds, aov_e, pair, ph_q;
    logic signed [15:0] e_acc, s;
    int mismatches, total_checks, tests, e_tests, n_done, k;
    acp_pkg::acp_conv_t conv;
    acp_pkg::acp_thr_t thr;
    logic [2:0] mlist [4] = '{acp_pkg::MODE_ACCUM, acp_pkg::MODE_BASIC, acp_pkg::MODE_AVG,
        acp_pkg::MODE_LPF};

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    acp_compute dut_u (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .conv(conv),
        .conv_phase(conv_phase), .conv_go(conv_go), .hold_cap_en(hold_cap_en), .thr(thr));
    acp_core_model core_u (.mclk(mclk), .sys_rst(sys_rst), .conv_go(conv_go), .rnd(rnd),
        .conv(conv), .conv_phase(conv_phase));

    task automatic compare_reg(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: register %h expected %h", $time, got, exp);
        end
    endtask

    task automatic compare_pin(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: pin %h expected %h", $time, got, exp);
        end
    endtask

    task print_verdict;
        if (mismatches == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // one single transfer; waits on hready with no assumed latency
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    function automatic logic [31:0] ctrlw(input logic go, input logic clr, input logic rc);
        ctrlw = 32'h0;
        ctrlw[acp_pkg::CTRL_MODE_LSB +: 3] = mode;
        ctrlw[acp_pkg::CTRL_SHIFT_LSB +: 3] = sh;
        ctrlw[acp_pkg::CTRL_DSEN_BIT] = ds;
        ctrlw[acp_pkg::CTRL_RCCLK_BIT] = rc;
        ctrlw[acp_pkg::CTRL_GO_BIT] = go;
        ctrlw[acp_pkg::CTRL_CLR_BIT] = clr;
        ctrlw[acp_pkg::CTRL_CAP_LSB +: 5] = cap;
    endfunction

    task automatic add(input logic signed [15:0] v);
        sum = {e_acc[15], e_acc} + {v[15], v};
        if (sum[16] != sum[15])
            aov_e = 1'b1;
        e_acc = sum[15:0];
    endtask

    // expected effect of one sample on accumulator, counter and tests
    task automatic step;
        logic tst;
        tst = 1'b1;
        case (mode)
            acp_pkg::MODE_ACCUM:
            begin
                add(s);
                if (e_cnt != 8'hff)
                    e_cnt++;
            end
            acp_pkg::MODE_AVG, acp_pkg::MODE_BURST:
            begin
                if (e_cnt >= rpt)
                begin
                    e_acc = s;
                    e_cnt = 8'h01;
                end
                else
                begin
                    add(s);
                    e_cnt++;
                end
                tst = e_cnt >= rpt;
            end
            acp_pkg::MODE_LPF:
            begin
                e_acc = e_acc - (e_acc >>> sh);
                add(s);
                if (e_cnt != 8'hff)
                    e_cnt++;
                tst = e_cnt >= rpt;
            end
            default:;
        endcase
        if (tst)
            e_tests++;
    endtask

    always @(posedge mclk)
    begin
        rnd <= $random(seed);
        ph_q <= conv_phase;
        if (!sys_rst && ph_q)
            compare_pin(hold_cap_en, 8'h00);
        if (!sys_rst && thr.test === 1'b1)
        begin
            tests++;
            compare_pin(thr.aov, aov_e);
        end
        if (!sys_rst && conv.done === 1'b1)
        begin
            n_done++;
            s = ds ? $signed({6'h0, conv.result}) - $signed({6'h0, last}) : {6'h0, conv.result};
            pair = ds && !pair;
            if (!pair)
                step;
            last = conv.result;
        end
    end

    task automatic convert;
        int n0;
        n0 = n_done;
        bus(1'b1, acp_pkg::OFS_STAT, 32'h3);
        bus(1'b1, acp_pkg::OFS_CTRL, ctrlw(1'b1, 1'b0, 1'b0));
        for (k = 0; k < 200 && n_done == n0; k++)
            @(posedge mclk);
        repeat (3) @(posedge mclk);
    endtask

    task automatic check_state;
        bus(1'b0, acp_pkg::OFS_ACC, 32'h0);
        compare_reg(rd, {16'h0, e_acc});
        compare_pin(hresp, 8'h00);
        bus(1'b0, acp_pkg::OFS_STAT, 32'h0);
        compare_reg({rd[15:8], rd[2], rd[0]}, {e_cnt, aov_e, 1'b1});
        flt = e_acc >>> sh;
        bus(1'b0, acp_pkg::OFS_FLTR, 32'h0);
        compare_reg(rd, {16'h0, flt});
        compare_reg(tests, e_tests);
    endtask

    task automatic clear_acc(input logic rc);
        logic signed [15:0] old_acc;
        old_acc = e_acc;
        bus(1'b1, acp_pkg::OFS_CTRL, ctrlw(1'b0, 1'b1, rc));
        e_acc = 16'sh0;
        e_cnt = 8'h00;
        aov_e = 1'b0;
        bus(1'b0, acp_pkg::OFS_CTRL, 32'h0);
        if (rc)
        begin
            compare_reg(rd[acp_pkg::CTRL_CLR_BIT], 32'h1);
            // still busy: the slow clear must not have landed yet
            bus(1'b0, acp_pkg::OFS_ACC, 32'h0);
            compare_reg(rd, {16'h0, old_acc});
        end
        repeat (6) @(posedge mclk);
    endtask

    initial
    begin
        {hsel, hwrite, htrans, haddr, hwdata, mode, sh, ds, rpt, cap} = '0;
        {e_acc, e_cnt, aov_e, pair, last, ph_q} = '0;
        {mismatches, total_checks, tests, e_tests, n_done} = '0;
        seed = 32'haf0c218e;
        hsize = 3'h2;
        sys_rst = 1'b1;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge mclk);
        foreach (mlist[i])
        begin
            bus(1'b0, {i[3:0], 4'h0}, 32'h0);
            compare_reg(rd, 32'h0);
        end
        bus(1'b0, 8'h40, 32'h0);
        compare_reg(rd, 32'h0);
        mode = acp_pkg::MODE_ACCUM;
        ds = 1'b1;
        convert;
        convert;
        check_state;
        ds = 1'b0;
        foreach (mlist[i])
        begin
            rv = $random(seed);
            mode = mlist[i];
            sh = 3'(rv[7:0] % 6);
            rpt = 8'(rv[15:8] % 4 + 1);
            cap = rv[20:16];
            bus(1'b1, acp_pkg::OFS_RPT, {24'h0, rpt});
            if (mode != acp_pkg::MODE_BASIC)
                clear_acc(1'b0);
            repeat (6)
            begin
                convert;
                check_state;
            end
            bus(1'b1, acp_pkg::OFS_CTRL, ctrlw(1'b0, 1'b0, 1'b0));
            repeat (3) @(posedge mclk);
            compare_pin(hold_cap_en, cap);
        end
        mode = acp_pkg::MODE_BURST;
        rpt = 8'h03;
        bus(1'b1, acp_pkg::OFS_RPT, {24'h0, rpt});
        e_acc = 16'sh0;
        e_cnt = 8'h00;
        bus(1'b1, acp_pkg::OFS_CTRL, ctrlw(1'b1, 1'b0, 1'b0));
        for (k = 0; k < 500 && e_cnt != rpt; k++)
            @(posedge mclk);
        repeat (4) @(posedge mclk);
        compare_pin(conv_go, 8'h00);
        check_state;
        mode = acp_pkg::MODE_ACCUM;
        clear_acc(1'b0);
        repeat (260) convert;
        bus(1'b0, acp_pkg::OFS_STAT, 32'h0);
        compare_reg({rd[15:8], rd[2]}, {8'hff, 1'b1});
        clear_acc(1'b1);
        bus(1'b0, acp_pkg::OFS_STAT, 32'h0);
        compare_reg({rd[15:8], rd[2]}, 32'h0);
        bus(1'b0, acp_pkg::OFS_ACC, 32'h0);
        compare_reg(rd, 32'h0);
        print_verdict;
    end

    // bound well above the expected length of the run
    initial
    begin
        repeat (60000) @(posedge mclk);
        mismatches++;
        print_verdict;
    end
endmodule
